/* File: design/csr_pkg.sv */
// Constants, types and register map of the core status, option and interrupt registers.
// Assumes one clock domain and a simple strobe register port from the core.
package csr_pkg;

    // Register offsets (8-bit file address, bank bit is address bit 7)
    localparam logic [7:0] OFF_STATUS_B0   = 8'h03;
    localparam logic [7:0] OFF_STATUS_B1   = 8'h83;
    localparam logic [7:0] OFF_INTCTL_B0   = 8'h0B;
    localparam logic [7:0] OFF_INTCTL_B1   = 8'h8B;
    localparam logic [7:0] OFF_OPTIONS     = 8'h81;
    localparam logic [7:0] OFF_PERIPH_EN   = 8'h8C;
    localparam logic [7:0] OFF_PERIPH_FLAG = 8'h0C;

    // Reset values
    localparam logic [7:0] RST_STATUS      = 8'hFF;
    localparam logic [7:0] RST_OPTIONS     = 8'hFF;
    localparam logic [7:0] RST_INTCTL      = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN   = 8'h00;
    localparam logic [7:0] RST_PERIPH_FLAG = 8'h00;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    // Status fields
    localparam int ST_CARRY    = 0;
    localparam int ST_NIBBLE   = 1;
    localparam int ST_ZERO     = 2;
    localparam int ST_SLEEP    = 3;
    localparam int ST_WDTEXP   = 4;
    localparam int ST_BANK     = 5;
    // Bits that only hardware may change through software writes
    localparam logic [7:0] ST_HW_ONLY_MASK = 8'h18;

    // Option fields
    localparam int OPT_RATE_LSB = 0;
    localparam int OPT_RATE_W   = 3;
    localparam int OPT_ASSIGN   = 3;
    localparam int OPT_EDGE     = 4;
    localparam int OPT_SOURCE   = 5;

    // Interrupt control fields
    localparam int IC_TIMER_FLAG = 2;
    localparam int IC_TIMER_EN   = 5;
    localparam int IC_PERIPH     = 6;
    localparam int IC_MASTER     = 7;

    // Peripheral enable / flag fields
    localparam int PF_COUNTER_OVF = 0;
    localparam int PF_CAPTURE     = 1;
    localparam int PF_PORT_CHANGE = 2;
    localparam int PF_SERIAL      = 3;
    localparam int PF_PUSHBUTTON  = 4;
    localparam int PF_WAKE        = 7;
    localparam logic [7:0] PF_IMPL_MASK = 8'h9F;

    // Timer rate code is one doubling above the watchdog rate code
    localparam logic [3:0] TIMER_SHIFT_BIAS = 4'h1;

    // ALU operation classes, one-hot
    typedef enum logic [4:0] {
        CSR_OP_ADD   = 5'b00001,
        CSR_OP_SUB   = 5'b00010,
        CSR_OP_LOGIC = 5'b00100,
        CSR_OP_ROTL  = 5'b01000,
        CSR_OP_ROTR  = 5'b10000
    } csr_aluop_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } csr_bus_s;

    // Logic ops and rotates carry their result or source in opA
    typedef struct packed {
        logic       valid;
        csr_aluop_e op;
        logic [7:0] opA;
        logic [7:0] opB;
    } csr_alu_s;

    typedef struct packed {
        logic wdtTimeout;
        logic sleepInstr;
        logic clrWdtInstr;
        logic timerOverflow;
    } csr_evt_s;

    typedef struct packed {
        logic       toWatchdog;
        logic [3:0] timerShift;
        logic [3:0] wdtShift;
        logic       fallingEdge;
        logic       externalSource;
    } csr_presc_s;

endpackage

/* File: design/csr_core_regs.sv */
// Core status, option, interrupt-control and peripheral enable/flag registers.
// Assumes the core drives instruction events and ALU results on clk_sys, one cycle each.
`timescale 1ns/1ps

module csr_core_regs
#(
    parameter int SYNC_STAGES = 3,
    parameter int CHANGE_PINS = 4
)
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // Register port
    input  wire csr_pkg::csr_bus_s regBus,
    output logic [7:0]             regRdata,
    // Core events and ALU results
    input  wire csr_pkg::csr_alu_s aluResult,
    input  wire csr_pkg::csr_evt_s coreEvent,
    // Peripheral events, one pulse per flag bit
    input  wire logic [7:0]        periphEvent,
    // Pins
    input  wire logic              externalCounterPin,
    input  wire logic [CHANGE_PINS-1:0] portChangePins,
    // Direct addressing
    input  wire logic [6:0]        directAddr,
    output logic [7:0]             directAddrFull,
    // Status and configuration outputs
    output logic                   watchdogExpiryFlag,
    output logic                   sleepEnteredFlag,
    output csr_pkg::csr_presc_s    prescaleCfg,
    output logic                   counterTick,
    output logic                   irqRequest
);
    import csr_pkg::*;

    if (SYNC_STAGES != 3) begin : gChkSync
        $error("SYNC_STAGES must be 3");
    end
    if (CHANGE_PINS != 4) begin : gChkPins
        $error("CHANGE_PINS must be 4");
    end

    logic [7:0] status;
    logic [7:0] options;
    logic [7:0] intCtl;
    logic [7:0] periphEn;
    logic [7:0] periphFlag;

    logic       wrStatus;
    logic       wrIntCtl;
    logic       wrOptions;
    logic       wrPeriphEn;
    logic       wrPeriphFlag;

    always_comb
    begin
        wrStatus     = regBus.wr && (regBus.addr == OFF_STATUS_B0 || regBus.addr == OFF_STATUS_B1);
        wrIntCtl     = regBus.wr && (regBus.addr == OFF_INTCTL_B0 || regBus.addr == OFF_INTCTL_B1);
        wrOptions    = regBus.wr && (regBus.addr == OFF_OPTIONS);
        wrPeriphEn   = regBus.wr && (regBus.addr == OFF_PERIPH_EN);
        wrPeriphFlag = regBus.wr && (regBus.addr == OFF_PERIPH_FLAG);
    end

    // ALU flag computation
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] addB;
    logic       addCin;
    logic       updZero;
    logic       updNibble;
    logic       updCarry;
    logic       aluZero;
    logic       aluNibble;
    logic       aluCarry;

    always_comb
    begin
        addB      = (aluResult.op == CSR_OP_SUB) ? ~aluResult.opB : aluResult.opB;
        addCin    = (aluResult.op == CSR_OP_SUB);
        sum9      = {1'b0, aluResult.opA} + {1'b0, addB} + {8'h00, addCin};
        sum5      = {1'b0, aluResult.opA[3:0]} + {1'b0, addB[3:0]} + {4'h0, addCin};
        updZero   = 1'b0;
        updNibble = 1'b0;
        updCarry  = 1'b0;
        aluZero   = 1'b0;
        aluNibble = 1'b0;
        aluCarry  = 1'b0;
        case (aluResult.op)
            // Two's complement add: carry set means no borrow
            CSR_OP_ADD, CSR_OP_SUB:
            begin
                updZero   = aluResult.valid;
                updNibble = aluResult.valid;
                updCarry  = aluResult.valid;
                aluZero   = (sum9[7:0] == 8'h00);
                aluNibble = sum5[4];
                aluCarry  = sum9[8];
            end
            CSR_OP_LOGIC:
            begin
                updZero = aluResult.valid;
                aluZero = (aluResult.opA == 8'h00);
            end
            CSR_OP_ROTL:
            begin
                updCarry = aluResult.valid;
                aluCarry = aluResult.opA[7];
            end
            CSR_OP_ROTR:
            begin
                updCarry = aluResult.valid;
                aluCarry = aluResult.opA[0];
            end
            default: updZero = 1'b0;
        endcase
    end

    // Status: bank and spare bits from software, ALU flags, reset-cause flags
    logic [7:0] next_status;

    always_comb
    begin
        next_status = status;
        if (wrStatus)
        begin
            // Bits 7:6 stay plain storage; software is expected to keep them clear
            next_status = (regBus.wdata & ~ST_HW_ONLY_MASK) | (status & ST_HW_ONLY_MASK);
        end
        if (updZero)
            next_status[ST_ZERO] = aluZero;
        if (updNibble)
            next_status[ST_NIBBLE] = aluNibble;
        if (updCarry)
            next_status[ST_CARRY] = aluCarry;
        if (coreEvent.clrWdtInstr)
        begin
            next_status[ST_WDTEXP] = 1'b1;
            next_status[ST_SLEEP]  = 1'b1;
        end
        if (coreEvent.sleepInstr)
        begin
            next_status[ST_WDTEXP] = 1'b1;
            next_status[ST_SLEEP]  = 1'b0;
        end
        // A timeout beats a coincident clear; sleep flag is left alone
        if (coreEvent.wdtTimeout)
            next_status[ST_WDTEXP] = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            status <= RST_STATUS;
        end
        else
        begin
            status <= next_status;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            options <= RST_OPTIONS;
        end
        else if (wrOptions)
        begin
            options <= regBus.wdata;
        end
    end

    // Interrupt control: timer flag set wins over a software clear
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            intCtl <= RST_INTCTL;
        end
        else
        begin
            if (wrIntCtl)
                intCtl <= regBus.wdata;
            if (coreEvent.timerOverflow)
                intCtl[IC_TIMER_FLAG] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            periphEn <= RST_PERIPH_EN;
        end
        else if (wrPeriphEn)
        begin
            periphEn <= regBus.wdata & PF_IMPL_MASK;
        end
    end

    // Pin synchronisers: three stages, a change counts once stages two and three agree
    logic [SYNC_STAGES-1:0] cntSync;
    logic                   cntStable;
    logic                   cntChange;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cntSync   <= '0;
            cntStable <= 1'b0;
        end
        else
        begin
            cntSync <= {cntSync[SYNC_STAGES-2:0], externalCounterPin};
            if (cntSync[1] == cntSync[2])
                cntStable <= cntSync[2];
        end
    end

    assign cntChange = (cntSync[1] == cntSync[2]) && (cntSync[2] != cntStable);

    logic [CHANGE_PINS-1:0] pinChange;

    for (genvar i = 0; i < CHANGE_PINS; i++) begin : gPin
        logic [SYNC_STAGES-1:0] pinSync;
        logic                   pinStable;

        always_ff @(posedge clk_sys or negedge rstn)
        begin
            if (!rstn)
            begin
                pinSync   <= '0;
                pinStable <= 1'b0;
            end
            else
            begin
                pinSync <= {pinSync[SYNC_STAGES-2:0], portChangePins[i]};
                if (pinSync[1] == pinSync[2])
                    pinStable <= pinSync[2];
            end
        end

        // Stable state starts low, so a pin held high at reset reports one change
        assign pinChange[i] = (pinSync[1] == pinSync[2]) && (pinSync[2] != pinStable);
    end

    // Peripheral flags: events set, software write stores, set wins
    logic [7:0] periphSet;

    always_comb
    begin
        periphSet                 = periphEvent & PF_IMPL_MASK;
        periphSet[PF_PORT_CHANGE] = periphEvent[PF_PORT_CHANGE] | (|pinChange);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            periphFlag <= RST_PERIPH_FLAG;
        end
        else if (wrPeriphFlag)
        begin
            periphFlag <= (regBus.wdata & PF_IMPL_MASK) | periphSet;
        end
        else
        begin
            periphFlag <= periphFlag | periphSet;
        end
    end

    // Counter tick on the selected pin transition
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            counterTick <= 1'b0;
        end
        else
        begin
            counterTick <= cntChange && (cntSync[2] != options[OPT_EDGE]);
        end
    end

    // Prescaler routing and ratios as log2 of the divide
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            prescaleCfg <= '0;
        end
        else
        begin
            prescaleCfg.toWatchdog     <= options[OPT_ASSIGN];
            prescaleCfg.wdtShift       <= {1'b0, options[OPT_RATE_LSB +: OPT_RATE_W]};
            prescaleCfg.timerShift     <= {1'b0, options[OPT_RATE_LSB +: OPT_RATE_W]}
                                          + TIMER_SHIFT_BIAS;
            prescaleCfg.fallingEdge    <= options[OPT_EDGE];
            prescaleCfg.externalSource <= options[OPT_SOURCE];
        end
    end

    // Bank-extended direct address
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            directAddrFull <= 8'h00;
        end
        else
        begin
            directAddrFull <= {status[ST_BANK], directAddr};
        end
    end

    // Reset-cause flags for the core to decode
    assign watchdogExpiryFlag = status[ST_WDTEXP];
    assign sleepEnteredFlag   = status[ST_SLEEP];

    // Interrupt request, registered; a flag is seen one cycle after it is set
    logic timerTerm;
    logic periphTerm;

    always_comb
    begin
        timerTerm  = intCtl[IC_TIMER_EN] && intCtl[IC_TIMER_FLAG];
        periphTerm = intCtl[IC_PERIPH] && (|(periphFlag & periphEn));
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            irqRequest <= 1'b0;
        end
        else
        begin
            irqRequest <= intCtl[IC_MASTER] && (timerTerm || periphTerm);
        end
    end

    // Read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            regRdata <= READ_ZERO;
        end
        else if (regBus.rd)
        begin
            case (regBus.addr)
                OFF_STATUS_B0, OFF_STATUS_B1: regRdata <= status;
                OFF_INTCTL_B0, OFF_INTCTL_B1: regRdata <= intCtl;
                OFF_OPTIONS:                  regRdata <= options;
                OFF_PERIPH_EN:                regRdata <= periphEn;
                OFF_PERIPH_FLAG:              regRdata <= periphFlag;
                default:                      regRdata <= READ_ZERO;
            endcase
        end
        else
        begin
            regRdata <= READ_ZERO;
        end
    end

endmodule // csr_core_regs

/* File: tb/csr_core_regs_checker.sv */
// Port-level assertions for the core status, option and interrupt registers.
// Assumes one clk_sys domain with rstn asynchronous, active low; bound below.
`timescale 1ns/1ps

module csr_core_regs_checker
#(
    parameter int SYNC_STAGES = 3,
    parameter int CHANGE_PINS = 4
)
(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rstn,
    // Watched ports
    input wire csr_pkg::csr_bus_s   regBus,
    input wire logic [7:0]          regRdata,
    input wire csr_pkg::csr_evt_s   coreEvent,
    input wire logic [6:0]          directAddr,
    input wire logic [7:0]          directAddrFull,
    input wire logic                watchdogExpiryFlag,
    input wire logic                sleepEnteredFlag,
    input wire csr_pkg::csr_presc_s prescaleCfg,
    input wire logic                counterTick,
    input wire logic                irqRequest
);
    import csr_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_timeout;
        coreEvent.wdtTimeout |=> !watchdogExpiryFlag;
    endproperty
    a_timeout: assert property (p_timeout) else $error("expiry flag kept");
    property p_sleep;
        coreEvent.sleepInstr && !coreEvent.wdtTimeout |=> watchdogExpiryFlag && !sleepEnteredFlag;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_clr;
        coreEvent.clrWdtInstr && !coreEvent.sleepInstr && !coreEvent.wdtTimeout
            |=> watchdogExpiryFlag && sleepEnteredFlag;
    endproperty
    a_clr: assert property (p_clr) else $error("clear flags wrong");
    property p_timeout_keeps;
        coreEvent.wdtTimeout && !coreEvent.sleepInstr && !coreEvent.clrWdtInstr
            |=> sleepEnteredFlag == $past(sleepEnteredFlag);
    endproperty
    a_timeout_keeps: assert property (p_timeout_keeps) else $error("sleep flag moved");
    property p_hw_only;
        !(coreEvent.wdtTimeout || coreEvent.sleepInstr || coreEvent.clrWdtInstr)
            |=> $stable({watchdogExpiryFlag, sleepEnteredFlag});
    endproperty
    a_hw_only: assert property (p_hw_only) else $error("flags moved without event");
    property p_rates;
        $past(rstn) |-> prescaleCfg.timerShift == prescaleCfg.wdtShift + 4'h1;
    endproperty
    a_rates: assert property (p_rates) else $error("rate offset wrong");
    property p_bank;
        $past(rstn) |-> directAddrFull[6:0] == $past(directAddr);
    endproperty
    a_bank: assert property (p_bank) else $error("direct address wrong");
    property p_en_zero;
        regBus.rd && regBus.addr == OFF_PERIPH_EN |=> regRdata[6:5] == 2'b00;
    endproperty
    a_en_zero: assert property (p_en_zero) else $error("unused enables read set");
    property p_tick;
        counterTick |=> !counterTick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick too long");

    c_irq: cover property (irqRequest);
    c_tick: cover property (counterTick);
    c_timeout: cover property (coreEvent.wdtTimeout ##1 !watchdogExpiryFlag);
endmodule // csr_core_regs_checker

bind csr_core_regs csr_core_regs_checker #(.SYNC_STAGES(SYNC_STAGES), .CHANGE_PINS(CHANGE_PINS))
    u_chk (.clk_sys(clk_sys), .rstn(rstn), .regBus(regBus), .regRdata(regRdata),
    .coreEvent(coreEvent), .directAddr(directAddr), .directAddrFull(directAddrFull),
    .watchdogExpiryFlag(watchdogExpiryFlag), .sleepEnteredFlag(sleepEnteredFlag),
    .prescaleCfg(prescaleCfg), .counterTick(counterTick), .irqRequest(irqRequest));

/* File: tb/csr_core_regs_test.sv */
// Self-checking bench for the core status, option and interrupt registers.
// Assumes the checker is bound in from its own file; the bench drives every port.
`timescale 1ns/1ps

module csr_core_regs_test;
    import csr_pkg::*;
    logic        clk_sys;
    logic        rstn;
    csr_bus_s    regBus;
    logic [7:0]  regRdata;
    csr_alu_s    aluResult;
    csr_evt_s    coreEvent;
    logic [7:0]  periphEvent;
    logic        externalCounterPin;
    logic [3:0]  portChangePins;
    logic [6:0]  directAddr;
    logic [7:0]  directAddrFull;
    logic        watchdogExpiryFlag;
    logic        sleepEnteredFlag;
    csr_presc_s  prescaleCfg;
    logic        counterTick;
    logic        irqRequest;
    logic [7:0]  rdq[$];
    logic        rdSeen = 1'b0;
    logic [7:0]  st;
    logic [31:0] seed;
    int          n_errors;
    int          compares;

    csr_core_regs dut
    (
        .clk_sys(clk_sys), .rstn(rstn), .regBus(regBus), .regRdata(regRdata),
        .aluResult(aluResult), .coreEvent(coreEvent), .periphEvent(periphEvent),
        .externalCounterPin(externalCounterPin), .portChangePins(portChangePins),
        .directAddr(directAddr), .directAddrFull(directAddrFull),
        .watchdogExpiryFlag(watchdogExpiryFlag), .sleepEnteredFlag(sleepEnteredFlag),
        .prescaleCfg(prescaleCfg), .counterTick(counterTick), .irqRequest(irqRequest)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] nextRand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Expected {zero, nibble, carry}; subtraction adds the two's complement
    function automatic logic [2:0] flags(input csr_aluop_e op, input logic [7:0] a,
                                         input logic [7:0] b, input logic [2:0] old);
        logic [8:0] s;
        logic [4:0] n;
        s = (op == CSR_OP_SUB) ? {1'b0, a} + {1'b0, ~b} + 9'h001 : {1'b0, a} + {1'b0, b};
        n = (op == CSR_OP_SUB) ? {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01
                               : {1'b0, a[3:0]} + {1'b0, b[3:0]};
        case (op)
            CSR_OP_LOGIC: return {a == 8'h00, old[1:0]};
            CSR_OP_ROTL: return {old[2:1], a[7]};
            CSR_OP_ROTR: return {old[2:1], a[0]};
            default: return {s[7:0] == 8'h00, n[4], s[8]};
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_sys);
        regBus <= '{a, d, w, !w};
        @(posedge clk_sys);
        regBus.wr <= 1'b0;
        regBus.rd <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a[6:0] == 7'h03)
            st = {d[7:5], st[4:3], d[2:0]};
        bus(a, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rdq.push_back(exp);
        bus(a, 8'h00, 1'b0);
    endtask

    task automatic evt(input csr_evt_s e);
        @(posedge clk_sys);
        coreEvent <= e;
        @(posedge clk_sys);
        coreEvent <= '0;
    endtask

    task automatic irqChk(input logic exp);
        repeat (2) @(posedge clk_sys);
        check({7'h00, irqRequest}, {7'h00, exp});
    endtask

    // Bounded watch for a tick; a missing or stray pulse both count
    task automatic waitTick(input logic exp);
        logic hit;
        hit = 1'b0;
        repeat (10)
        begin
            @(posedge clk_sys);
            if (counterTick === 1'b1)
                hit = 1'b1;
        end
        check({7'h00, hit}, {7'h00, exp});
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_sys)
    begin
        if (rdSeen === 1'b1 && rdq.size() > 0)
            check(regRdata, rdq.pop_front());
        rdSeen <= regBus.rd;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        close_out();
    end

    initial
    begin
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] d;
        csr_aluop_e op;
        seed = 32'd20721;
        n_errors = 0;
        compares = 0;
        st = 8'hFF;
        regBus = '0;
        aluResult = '0;
        coreEvent = '0;
        periphEvent = 8'h00;
        externalCounterPin = 1'b0;
        portChangePins = 4'h0;
        directAddr = 7'h00;
        rstn = 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;

        rd(OFF_STATUS_B1, 8'hFF);
        rd(OFF_OPTIONS, 8'hFF);
        rd(OFF_INTCTL_B1, 8'h00);
        rd(OFF_PERIPH_EN, 8'h00);
        rd(8'h8D, 8'h00);
        $display("test reset done");

        wr(OFF_STATUS_B1, 8'hC0);
        rd(OFF_STATUS_B0, 8'hD8);
        wr(OFF_STATUS_B0, 8'h27);
        rd(OFF_STATUS_B1, st);
        directAddr <= 7'(nextRand());
        repeat (2) @(posedge clk_sys);
        check(directAddrFull, {1'b1, directAddr});
        $display("test status write done");

        for (int i = 0; i < 25; i++)
        begin
            a = (i < 2) ? 8'h88 : nextRand();
            b = (i == 0) ? 8'h78 : (i == 1) ? a : nextRand();
            op = csr_aluop_e'(5'h01 << (i % 5));
            @(posedge clk_sys);
            aluResult <= '{1'b1, op, a, b};
            @(posedge clk_sys);
            aluResult.valid <= 1'b0;
            st[2:0] = flags(op, a, b, st[2:0]);
            rd(OFF_STATUS_B1, st);
        end
        // Same-cycle write loses the three flags to the result
        @(posedge clk_sys);
        regBus <= '{OFF_STATUS_B1, 8'h07, 1'b1, 1'b0};
        aluResult <= '{1'b1, CSR_OP_ADD, 8'h00, 8'h00};
        @(posedge clk_sys);
        regBus.wr <= 1'b0;
        aluResult.valid <= 1'b0;
        st = {3'b000, st[4:3], 3'b100};
        rd(OFF_STATUS_B1, st);
        check(directAddrFull, {1'b0, directAddr});
        $display("test alu flags done");

        for (int e = 0; e < 8; e++)
        begin
            evt(csr_evt_s'({e[2:0], 1'b0}));
            if (e[2])
                st[4] = 1'b0;
            else if (e[1] || e[0])
                st[4] = 1'b1;
            if (e[1])
                st[3] = 1'b0;
            else if (e[0])
                st[3] = 1'b1;
            rd(OFF_STATUS_B1, st);
            check({6'h00, watchdogExpiryFlag, sleepEnteredFlag}, {6'h00, st[4:3]});
        end
        $display("test reset flags done");

        for (int c = 0; c < 8; c++)
        begin
            d = {3'b111, c[1], c[0], c[2:0]};
            wr(OFF_OPTIONS, d);
            rd(OFF_OPTIONS, d);
            check({prescaleCfg.timerShift, prescaleCfg.wdtShift},
                  {c[3:0] + 4'h1, 1'b0, c[2:0]});
            check({5'h00, prescaleCfg.externalSource, prescaleCfg.toWatchdog,
                   prescaleCfg.fallingEdge}, {5'h00, 1'b1, c[0], c[1]});
        end
        for (int f = 0; f < 2; f++)
        begin
            wr(OFF_OPTIONS, {3'b001, f[0], 4'h8});
            externalCounterPin <= 1'b1;
            waitTick(!f[0]);
            externalCounterPin <= 1'b0;
            waitTick(f[0]);
        end
        $display("test options done");

        wr(OFF_INTCTL_B0, 8'h00);
        evt('{1'b0, 1'b0, 1'b0, 1'b1});
        rd(OFF_INTCTL_B1, 8'h04);
        wr(OFF_INTCTL_B0, 8'h24);
        irqChk(1'b0);
        wr(OFF_INTCTL_B0, 8'hA4);
        irqChk(1'b1);
        wr(OFF_INTCTL_B0, 8'h84);
        irqChk(1'b0);
        wr(OFF_INTCTL_B0, 8'hA0);
        rd(OFF_INTCTL_B1, 8'hA0);
        irqChk(1'b0);
        @(posedge clk_sys);
        periphEvent <= 8'h01;
        @(posedge clk_sys);
        periphEvent <= 8'h00;
        rd(OFF_PERIPH_FLAG, 8'h01);
        wr(OFF_PERIPH_EN, 8'hFF);
        rd(OFF_PERIPH_EN, 8'h9F);
        wr(OFF_INTCTL_B0, 8'h80);
        irqChk(1'b0);
        wr(OFF_INTCTL_B0, 8'hC0);
        irqChk(1'b1);
        wr(OFF_PERIPH_EN, 8'h9E);
        irqChk(1'b0);
        for (int i = 0; i < 8; i++)
        begin
            a = nextRand();
            b = nextRand();
            wr(OFF_PERIPH_FLAG, b);
            wr(OFF_PERIPH_EN, a);
            rd(OFF_PERIPH_EN, a & PF_IMPL_MASK);
            irqChk(|(a & b & PF_IMPL_MASK));
        end
        wr(OFF_PERIPH_FLAG, 8'h00);
        portChangePins <= 4'h8;
        repeat (8) @(posedge clk_sys);
        rd(OFF_PERIPH_FLAG, 8'h04);
        $display("test interrupts done");
        repeat (3) @(posedge clk_sys);
        close_out();
    end
endmodule // csr_core_regs_test
